// file: pdmi2s_pkg.sv
package pdmi2s_pkg;
	// ****************************************
	// Clock and rate figures
	// ****************************************
	localparam int SYS_CLK_HZ      = 20_000_000;
	localparam int MIC_CLK_HZ      = 3_072_000;
	localparam int MCLK_6M_HZ      = 6_144_000;
	localparam int MCLK_12M_HZ     = 12_288_000;
	localparam int MCLK_24M_HZ     = 24_576_000;
	localparam int BCLK_16K_HZ     = 1_024_000;
	localparam int BCLK_48K_HZ     = 3_072_000;
	localparam int BITS_PER_FRAME  = 64;
	localparam int SLOT_BITS       = 32;
	localparam int FRAME_CNT_W     = 7;
	localparam int HALF_DIV_W      = 3;

	// ****************************************
	// Master clock rate select encodings
	// ****************************************
	localparam logic [1:0] MCLK_SEL_6M  = 2'h0;
	localparam logic [1:0] MCLK_SEL_12M = 2'h1;
	localparam logic [1:0] MCLK_SEL_24M = 2'h2;

	// Master clock rising edges per half period of the microphone clock
	localparam logic [HALF_DIV_W-1:0] HALF_6M  =
		HALF_DIV_W'(MCLK_6M_HZ / MIC_CLK_HZ / 2);
	localparam logic [HALF_DIV_W-1:0] HALF_12M =
		HALF_DIV_W'(MCLK_12M_HZ / MIC_CLK_HZ / 2);
	localparam logic [HALF_DIV_W-1:0] HALF_24M =
		HALF_DIV_W'(MCLK_24M_HZ / MIC_CLK_HZ / 2);

	localparam logic [FRAME_CNT_W-1:0] FRAME_BITS =
		FRAME_CNT_W'(BITS_PER_FRAME);
endpackage : pdmi2s_pkg

// file: pdmi2s_front_end.sv
// Overview of operation
// - Sample shared mic line on both edges
// - Divide master clock to 3.072MHz mic clock
// - I2S slave: send out, receive reference
// - One host bit/word clock pair, both directions
// - Master clock 6.144, 12.288 or 24.576MHz
// - Bit clock 1.024MHz or 3.072MHz by rate
// - Word clock is bit clock over 64
// - MSB one bit clock after word edge
`timescale 1ns/100ps
module pdmi2s_front_end (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        masterClk,
	input  wire logic [1:0]  masterClkSel,
	input  wire logic        rateSel48k,
	output logic             micClk,
	input  wire logic        micData,
	output logic             pdmLeftBit,
	output logic             pdmRightBit,
	output logic             pdmLeftValid,
	output logic             pdmRightValid,
	input  wire logic        serialAudioBitClock,
	input  wire logic        serial_audio_word_clock,
	input  wire logic        serialDataIn,
	output logic             serialDataOut,
	input  wire logic [31:0] txLeftWord,
	input  wire logic [31:0] txRightWord,
	output logic             txWordTaken,
	output logic [31:0]      rxWord,
	output logic             rxWordRight,
	output logic             rxWordValid,
	output logic             frameError
);
	// ****************************************
	// Microphone clock divider and capture
	// ****************************************
	logic                                 mclkPrev_reg, mclkPrev_next;
	logic [pdmi2s_pkg::HALF_DIV_W-1:0]    divCnt_reg, divCnt_next;
	logic                                 micClk_reg, micClk_next;
	logic                                 pdmL_reg, pdmL_next;
	logic                                 pdmR_reg, pdmR_next;
	logic                                 pdmLV_reg, pdmLV_next;
	logic                                 pdmRV_reg, pdmRV_next;
	logic [pdmi2s_pkg::HALF_DIV_W-1:0]    halfDiv;

	function automatic logic [pdmi2s_pkg::HALF_DIV_W-1:0] halfOf(
		input logic [1:0] sel);
		case (sel)
			pdmi2s_pkg::MCLK_SEL_6M:  halfOf = pdmi2s_pkg::HALF_6M;
			pdmi2s_pkg::MCLK_SEL_12M: halfOf = pdmi2s_pkg::HALF_12M;
			default:                  halfOf = pdmi2s_pkg::HALF_24M;
		endcase
	endfunction : halfOf

	always_comb begin
		halfDiv       = halfOf(masterClkSel);
		mclkPrev_next = masterClk;
		divCnt_next   = divCnt_reg;
		micClk_next   = micClk_reg;
		pdmL_next     = pdmL_reg;
		pdmR_next     = pdmR_reg;
		pdmLV_next    = 1'b0;
		pdmRV_next    = 1'b0;
		if (masterClk && !mclkPrev_reg) begin
			if (divCnt_reg + 1'b1 >= halfDiv) begin
				divCnt_next = '0;
				micClk_next = !micClk_reg;
				if (micClk_reg) begin
					// Falling edge: left mic drove since rising
					pdmL_next  = micData;
					pdmLV_next = 1'b1;
				end else begin
					// Rising edge: right mic drove since falling
					pdmR_next  = micData;
					pdmRV_next = 1'b1;
				end
			end else begin
				divCnt_next = divCnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mclkPrev_reg <= 1'b0;
			divCnt_reg   <= '0;
			micClk_reg   <= 1'b0;
			pdmL_reg     <= 1'b0;
			pdmR_reg     <= 1'b0;
			pdmLV_reg    <= 1'b0;
			pdmRV_reg    <= 1'b0;
		end else begin
			mclkPrev_reg <= mclkPrev_next;
			divCnt_reg   <= divCnt_next;
			micClk_reg   <= micClk_next;
			pdmL_reg     <= pdmL_next;
			pdmR_reg     <= pdmR_next;
			pdmLV_reg    <= pdmLV_next;
			pdmRV_reg    <= pdmRV_next;
		end
	end

	assign micClk        = micClk_reg;
	assign pdmLeftBit    = pdmL_reg;
	assign pdmRightBit   = pdmR_reg;
	assign pdmLeftValid  = pdmLV_reg;
	assign pdmRightValid = pdmRV_reg;

	// ****************************************
	// I2S slave port
	// ****************************************
	logic                                 bclkPrev_reg, bclkPrev_next;
	logic                                 wclkLast_reg, wclkLast_next;
	logic                                 loadPend_reg, loadPend_next;
	logic [31:0]                          rxShift_reg, rxShift_next;
	logic [31:0]                          txShift_reg, txShift_next;
	logic                                 sdo_reg, sdo_next;
	logic                                 taken_reg, taken_next;
	logic [31:0]                          rxWord_reg, rxWord_next;
	logic                                 rxRight_reg, rxRight_next;
	logic                                 rxValid_reg, rxValid_next;
	logic [pdmi2s_pkg::FRAME_CNT_W-1:0]   bitCnt_reg, bitCnt_next;
	logic                                 frameErr_reg, frameErr_next;
	logic                                 bclkRise, bclkFall;

	always_comb begin
		// Both directions follow this one bit clock
		bclkRise      = serialAudioBitClock && !bclkPrev_reg;
		bclkFall      = !serialAudioBitClock && bclkPrev_reg;
		bclkPrev_next = serialAudioBitClock;
		wclkLast_next = wclkLast_reg;
		loadPend_next = loadPend_reg;
		rxShift_next  = rxShift_reg;
		txShift_next  = txShift_reg;
		sdo_next      = sdo_reg;
		taken_next    = 1'b0;
		rxWord_next   = rxWord_reg;
		rxRight_next  = rxRight_reg;
		rxValid_next  = 1'b0;
		bitCnt_next   = bitCnt_reg;
		frameErr_next = frameErr_reg;
		if (bclkRise) begin
			rxShift_next  = {rxShift_reg[30:0], serialDataIn};
			wclkLast_next = serial_audio_word_clock;
			bitCnt_next   = bitCnt_reg + 1'b1;
			if (serial_audio_word_clock != wclkLast_reg) begin
				// Bit at the word edge is the old slot's LSB
				rxWord_next   = {rxShift_reg[30:0], serialDataIn};
				rxRight_next  = wclkLast_reg;
				rxValid_next  = 1'b1;
				loadPend_next = 1'b1;
				if (serial_audio_word_clock) begin
					// Frame runs from word rise to word rise
					bitCnt_next   = '0;
					frameErr_next = (bitCnt_reg + 1'b1 !=
						pdmi2s_pkg::FRAME_BITS);
				end
			end
		end
		if (bclkFall) begin
			if (loadPend_reg) begin
				// MSB one bit clock after the word edge
				txShift_next  = wclkLast_reg ? {txRightWord[30:0], 1'b0}
					: {txLeftWord[30:0], 1'b0};
				sdo_next      = wclkLast_reg ? txRightWord[31]
					: txLeftWord[31];
				taken_next    = 1'b1;
				loadPend_next = 1'b0;
			end else begin
				sdo_next     = txShift_reg[31];
				txShift_next = {txShift_reg[30:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bclkPrev_reg <= 1'b0;
			wclkLast_reg <= 1'b0;
			loadPend_reg <= 1'b0;
			rxShift_reg  <= '0;
			txShift_reg  <= '0;
			sdo_reg      <= 1'b0;
			taken_reg    <= 1'b0;
			rxWord_reg   <= '0;
			rxRight_reg  <= 1'b0;
			rxValid_reg  <= 1'b0;
			bitCnt_reg   <= '0;
			frameErr_reg <= 1'b0;
		end else begin
			bclkPrev_reg <= bclkPrev_next;
			wclkLast_reg <= wclkLast_next;
			loadPend_reg <= loadPend_next;
			rxShift_reg  <= rxShift_next;
			txShift_reg  <= txShift_next;
			sdo_reg      <= sdo_next;
			taken_reg    <= taken_next;
			rxWord_reg   <= rxWord_next;
			rxRight_reg  <= rxRight_next;
			rxValid_reg  <= rxValid_next;
			bitCnt_reg   <= bitCnt_next;
			frameErr_reg <= frameErr_next;
		end
	end

	// Rate select is informative; timing follows the host clocks
	logic unusedRate;
	assign unusedRate    = rateSel48k;
	assign serialDataOut = sdo_reg;
	assign txWordTaken   = taken_reg;
	assign rxWord        = rxWord_reg;
	assign rxWordRight   = rxRight_reg;
	assign rxWordValid   = rxValid_reg;
	assign frameError    = frameErr_reg;
endmodule : pdmi2s_front_end

// file: pdmi2s_sva.sv
`timescale 1ns/100ps
module pdmi2s_sva (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic masterClk,
	input wire logic [1:0] masterClkSel,
	input wire logic micClk,
	input wire logic micData,
	input wire logic pdmLeftBit,
	input wire logic pdmRightBit,
	input wire logic pdmLeftValid,
	input wire logic pdmRightValid,
	input wire logic serialAudioBitClock,
	input wire logic serial_audio_word_clock,
	input wire logic serialDataOut,
	input wire logic txWordTaken,
	input wire logic rxWordRight,
	input wire logic rxWordValid
);
	// ****
	// Port rules
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	mic_div_a: assert property (masterClkSel == pdmi2s_pkg::MCLK_SEL_6M &&
		$rose(masterClk) |=> $changed(micClk)) else $error("mic clock slow");
	mic_cause_a: assert property ($changed(micClk) |->
		$past(masterClk) && !$past(masterClk, 2)) else $error("mic clock odd");
	left_take_a: assert property ($fell(micClk) |-> pdmLeftValid &&
		!pdmRightValid && pdmLeftBit == $past(micData)) else $error("left bit");
	right_take_a: assert property ($rose(micClk) |-> pdmRightValid &&
		!pdmLeftValid && pdmRightBit == $past(micData)) else $error("right bit");
	left_pulse_a: assert property (pdmLeftValid |->
		$fell(micClk) ##1 !pdmLeftValid) else $error("left pulse");
	dout_fall_a: assert property ($changed(serialDataOut) |->
		$past(serialAudioBitClock, 2) && !$past(serialAudioBitClock))
		else $error("data out edge");
	rx_word_a: assert property (rxWordValid |-> $past(serialAudioBitClock) &&
		!$past(serialAudioBitClock, 2) &&
		rxWordRight != $past(serial_audio_word_clock)) else $error("rx word");
	tx_msb_a: assert property (rxWordValid |-> ##[1:16] txWordTaken)
		else $error("tx load late");
	cover property (pdmRightValid);
	cover property (rxWordValid && rxWordRight);
	cover property (txWordTaken);
endmodule : pdmi2s_sva
bind pdmi2s_front_end pdmi2s_sva i_pdmi2s_sva (.clk, .rst_b, .masterClk,
	.masterClkSel, .micClk, .micData, .pdmLeftBit, .pdmRightBit, .pdmLeftValid,
	.pdmRightValid, .serialAudioBitClock, .serial_audio_word_clock,
	.serialDataOut, .txWordTaken, .rxWordRight, .rxWordValid);

// file: pdmi2s_host_model.sv
`timescale 1ns/100ps
module pdmi2s_host_model #(parameter logic [31:0] REF_L = 32'h0,
	parameter logic [31:0] REF_R = 32'h0) (
	input wire logic clk,
	input wire logic micClk,
	input wire logic serialDataOut,
	output logic micData,
	output logic serialAudioBitClock,
	output logic serial_audio_word_clock,
	output logic serialDataIn,
	output logic [31:0] hostLeft,
	output logic [31:0] hostRight
);
	// ****
	// Mic pair and host
	// ****
	logic [2:0] div = 3'h0;
	logic [4:0] idx = 5'h0;
	logic [31:0] txSh = 32'h0;
	logic [31:0] rxSh = 32'h0;
	logic lastWc = 1'b0;
	logic [7:0] mic = 8'h4d;
	initial begin
		serial_audio_word_clock = 1'b0;
		serialDataIn = 1'b0;
		micData = 1'b0;
	end
	always @(posedge clk) div <= #1 div + 3'h1;
	assign serialAudioBitClock = div[2];
	always @(micClk) begin
		mic <= {mic[6:0], mic[7]};
		micData <= #5 mic[0];
	end
	always @(negedge serialAudioBitClock) begin
		idx <= idx + 5'h1;
		serialDataIn <= txSh[31];
		txSh <= txSh << 1;
		if (idx == 5'h1f) begin
			serial_audio_word_clock <= !serial_audio_word_clock;
			txSh <= serial_audio_word_clock ? REF_L : REF_R;
		end
	end
	always @(posedge serialAudioBitClock) begin
		rxSh = {rxSh[30:0], serialDataOut};
		if (serial_audio_word_clock != lastWc && lastWc) hostRight <= rxSh;
		if (serial_audio_word_clock != lastWc && !lastWc) hostLeft <= rxSh;
		lastWc <= serial_audio_word_clock;
	end
endmodule : pdmi2s_host_model

// file: pdmi2s_front_end_test.sv
`timescale 1ns/100ps
module pdmi2s_front_end_test;
	// ****
	// Bench
	// ****
	localparam logic [31:0] REF_L = 32'h8123_4567;
	localparam logic [31:0] REF_R = 32'h5a0f_c3e1;
	logic clk = 0, rst_b = 0, rateSel48k = 1;
	logic [1:0] mc = 2'h0, masterClkSel = 2'h0;
	logic [31:0] txLeftWord = 32'hc001_d00d, txRightWord = 32'h1357_9bdf;
	wire masterClk, micClk, micData, pdmLeftBit, pdmRightBit, pdmLeftValid;
	wire pdmRightValid, serialAudioBitClock, serial_audio_word_clock;
	wire serialDataIn, serialDataOut, txWordTaken, rxWordRight, rxWordValid;
	wire frameError;
	wire [31:0] rxWord, hostLeft, hostRight;
	int errors = 0, n_tests = 0;
	always #25 clk = !clk;
	always @(posedge clk) mc <= #1 mc + 2'h1;
	assign masterClk = mc[1] && rst_b;
	pdmi2s_front_end i_pdmi2s_front_end (.clk, .rst_b, .masterClk,
		.masterClkSel, .rateSel48k, .micClk, .micData, .pdmLeftBit,
		.pdmRightBit, .pdmLeftValid, .pdmRightValid, .serialAudioBitClock,
		.serial_audio_word_clock, .serialDataIn, .serialDataOut, .txLeftWord,
		.txRightWord, .txWordTaken, .rxWord, .rxWordRight, .rxWordValid,
		.frameError);
	pdmi2s_host_model #(.REF_L(REF_L), .REF_R(REF_R)) i_pdmi2s_host_model (
		.clk, .micClk, .serialDataOut, .micData, .serialAudioBitClock,
		.serial_audio_word_clock, .serialDataIn, .hostLeft, .hostRight);
	task check(string name, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task conclude();
		$display("errors %0d comparisons %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : conclude
	task mic_rates();
		int k;
		int n;
		for (int s = 0; s < 3; s++) begin
			#1 masterClkSel = 2'(s);
			repeat (40) @(posedge clk);
			for (k = 0; pdmLeftValid !== 1'b1 && k < 99; k++) @(posedge clk);
			for (n = 1; n < 99; n++) begin
				@(posedge clk);
				if (pdmRightValid === 1'b1) break;
			end
			check("mic half period", 32'(4 << s), 32'(n));
		end
	endtask : mic_rates
	task rx_ref();
		int k;
		for (int w = 0; w < 2; w++) begin
			k = 0;
			do begin
				@(posedge clk);
				k++;
			end while (rxWordValid !== 1'b1 && k < 600);
			check("reference", rxWordRight ? REF_R : REF_L, rxWord);
		end
	endtask : rx_ref
	task tx_out();
		check("host left", txLeftWord, hostLeft);
		check("host right", txRightWord, hostRight);
		check("frame error", 32'h0, 32'(frameError));
		#1 txLeftWord = 32'h0ff1_2ee8;
		repeat (1100) @(posedge clk);
		check("new left", 32'h0ff1_2ee8, hostLeft);
	endtask : tx_out
	initial begin
		#300000;
		errors++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 rst_b = 1;
		mic_rates();
		repeat (1100) @(posedge clk);
		rx_ref();
		tx_out();
		conclude();
	end
endmodule : pdmi2s_front_end_test
